// ===== tmz_defines.svh
`ifndef TMZ_DEFINES_SVH
`define TMZ_DEFINES_SVH
`define TMZ_OFF_OPTION 8'h00
`define TMZ_OFF_COUNT 8'h04
`define TMZ_OFF_INTCTL 8'h08
`define TMZ_OFF_IRQ_STATUS 8'h0c
`define TMZ_OFF_IRQ_MASK 8'h10
`define TMZ_OPT_PULLUP_DIS 7
`define TMZ_OPT_EXT_EDGE 6
`define TMZ_OPT_SRC 5
`define TMZ_OPT_EDGE 4
`define TMZ_OPT_ASSIGN 3
`define TMZ_ICF_OVF_IE 5
`define TMZ_ICF_OVF_FLAG 2
`define TMZ_OPTION_RESET 8'hff
`define TMZ_INTCTL_RESET 8'h00
`define TMZ_WRITE_INHIBIT 2'h2
`define TMZ_PHASES 2'h3
`define TMZ_RESP_OKAY 2'h0
`define TMZ_RESP_SLVERR 2'h2
`endif

// ===== tmz_pkg.sv
package tmz_pkg;
    typedef struct packed {
        logic pullup_dis;
        logic ext_edge;
        logic src;
        logic edge_sel;
        logic assign_wdt;
        logic [2:0] rate;
    } tmz_option_t;
    typedef enum logic [1:0] {
        TMZ_PH1,
        TMZ_PH2,
        TMZ_PH3,
        TMZ_PH4
    } tmz_phase_t;
endpackage

// ===== tmz_timer.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tmz_defines.svh"
module tmz_timer
    import tmz_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sleep_i,
    input wire logic ext_count_pin_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic watchdog_tick_i,
    output logic watchdog_tick_o,
    output logic porta_pullup_disable_o,
    output logic ext_irq_edge_select_o,
    output logic overflow_irq_o,
    output logic irq_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    tmz_option_t option_reg;
    logic [7:0] count_reg;
    logic [7:0] intctl_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] presc_reg;
    logic [1:0] inhibit_reg;
    logic load_pend_reg;
    logic [7:0] load_val_reg;
    tmz_phase_t phase_reg;
    logic [2:0] pin_sync_reg;
    logic ext_level_reg;
    logic [31:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic [31:0] rdata_reg;

    // Instruction cycle strobe at the fourth phase
    wire cyc_end = (phase_reg == TMZ_PH4);
    wire sample_phase = (phase_reg == TMZ_PH2) || (phase_reg == TMZ_PH4);
    wire run = !sleep_i;

    // Three-stage pin synchroniser; change taken when stages two and three agree
    wire pin_stable = (pin_sync_reg[1] == pin_sync_reg[2]);
    wire pin_rise = pin_stable && pin_sync_reg[1] && !ext_level_reg;
    wire pin_fall = pin_stable && !pin_sync_reg[1] && ext_level_reg;
    wire ext_edge = option_reg.edge_sel ? pin_fall : pin_rise;
    wire src_tick = option_reg.src ? ext_edge : cyc_end;

    wire presc_to_timer = !option_reg.assign_wdt;
    wire presc_in = presc_to_timer ? src_tick : watchdog_tick_i;
    wire [7:0] presc_inc = presc_reg + 8'h01;
    // Timer taps bit rate, watchdog taps one below; code 0 to watchdog is 1:1
    wire [2:0] rate = option_reg.rate;
    wire timer_presc_out = presc_reg[rate];
    // Low rate bits all ones: this tick completes one watchdog period
    wire [7:0] wdt_mask = (8'h01 << rate) - 8'h01;
    wire wdt_presc_out = presc_in && ((presc_reg & wdt_mask) == wdt_mask);
    // One-cycle pulse when the tapped bit falls at this prescaler step
    wire presc_falls = presc_in && timer_presc_out && !presc_inc[rate];

    // Timer-side increment: prescaler falling output or direct source
    wire timer_inc_raw = presc_to_timer ? presc_falls : src_tick;
    logic inc_pend_reg;
    wire inc_now = run && inc_pend_reg && sample_phase && (inhibit_reg == 2'h0)
                   && !load_pend_reg;
    wire wrap = inc_now && (count_reg == 8'hff);

    // Register bus decode
    wire aw_ok = aw_held_reg || s_axi_awvalid;
    wire w_ok = w_held_reg || s_axi_wvalid;
    wire [31:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire do_write = aw_ok && w_ok && !s_axi_bvalid;
    wire wr_lane0 = do_write && ws[0];
    wire [7:0] wsel = wa[7:0];
    wire wr_option = wr_lane0 && (wsel == `TMZ_OFF_OPTION);
    wire wr_count = wr_lane0 && (wsel == `TMZ_OFF_COUNT);
    wire wr_intctl = wr_lane0 && (wsel == `TMZ_OFF_INTCTL);
    wire wr_mask = wr_lane0 && (wsel == `TMZ_OFF_IRQ_MASK);
    wire wr_mapped = (wsel == `TMZ_OFF_OPTION) || (wsel == `TMZ_OFF_COUNT)
                     || (wsel == `TMZ_OFF_INTCTL) || (wsel == `TMZ_OFF_IRQ_STATUS)
                     || (wsel == `TMZ_OFF_IRQ_MASK);
    wire do_read = s_axi_arvalid && !s_axi_rvalid;
    wire [7:0] rsel = s_axi_araddr[7:0];
    wire rd_status = do_read && (rsel == `TMZ_OFF_IRQ_STATUS);
    logic [7:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (rsel)
            `TMZ_OFF_OPTION: rd_val = option_reg;
            `TMZ_OFF_COUNT: rd_val = count_reg;
            `TMZ_OFF_INTCTL: rd_val = intctl_reg;
            `TMZ_OFF_IRQ_STATUS: rd_val = irq_status_reg;
            `TMZ_OFF_IRQ_MASK: rd_val = irq_mask_reg;
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rdata = rdata_reg;

    assign porta_pullup_disable_o = option_reg.pullup_dis;
    assign ext_irq_edge_select_o = option_reg.ext_edge;
    assign watchdog_tick_o = option_reg.assign_wdt ? wdt_presc_out : watchdog_tick_i;
    assign overflow_irq_o = intctl_reg[`TMZ_ICF_OVF_FLAG]
                            && intctl_reg[`TMZ_ICF_OVF_IE];
    assign irq_o = |(irq_status_reg & irq_mask_reg);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= TMZ_PH1;
            pin_sync_reg <= 3'h0;
            ext_level_reg <= 1'b0;
        end else begin
            if (run) begin
                phase_reg <= tmz_phase_t'(phase_reg + 2'h1);
            end
            pin_sync_reg <= {pin_sync_reg[1:0], ext_count_pin_i};
            if (pin_stable) begin
                ext_level_reg <= pin_sync_reg[1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_reg <= 8'h00;
            inc_pend_reg <= 1'b0;
        end else begin
            if ((wr_count && presc_to_timer)
                || (watchdog_clear_instr_i && !presc_to_timer)) begin
                presc_reg <= 8'h00;
            end else if (run && presc_in) begin
                presc_reg <= presc_inc;
            end
            if (inc_now || wr_count) begin
                inc_pend_reg <= 1'b0;
            end else if (run && timer_inc_raw) begin
                inc_pend_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            option_reg <= `TMZ_OPTION_RESET;
            intctl_reg <= `TMZ_INTCTL_RESET;
            irq_status_reg <= 8'h00;
            irq_mask_reg <= 8'h00;
            inhibit_reg <= 2'h0;
            load_pend_reg <= 1'b0;
            load_val_reg <= 8'h00;
        end else begin
            if (wr_option) begin
                option_reg <= wd[7:0];
            end
            if (wr_intctl) begin
                intctl_reg <= wd[7:0];
            end
            if (wrap) begin
                intctl_reg[`TMZ_ICF_OVF_FLAG] <= 1'b1;
            end
            if (wr_mask) begin
                irq_mask_reg <= {7'h00, wd[0]};
            end
            if (rd_status) begin
                irq_status_reg <= 8'h00;
            end
            if (wrap) begin
                irq_status_reg[0] <= 1'b1;
            end
            if (wr_count) begin
                inhibit_reg <= `TMZ_WRITE_INHIBIT;
                load_pend_reg <= 1'b1;
                load_val_reg <= wd[7:0];
            end else begin
                if (cyc_end && run && inhibit_reg != 2'h0) begin
                    inhibit_reg <= inhibit_reg - 2'h1;
                end
                if (inhibit_reg == 2'h0) begin
                    load_pend_reg <= 1'b0;
                end
            end
        end
    end

    // Count has no reset so it holds across device resets
    always_ff @(posedge clk_i) begin
        if (load_pend_reg && inhibit_reg == 2'h0 && !wr_count) begin
            count_reg <= load_val_reg;
        end else if (inc_now) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            rdata_reg <= 32'h0;
        end else begin
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `TMZ_RESP_OKAY : `TMZ_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                    wstrb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                rdata_reg <= {24'h0, rd_val};
                s_axi_rresp <= rd_hit ? `TMZ_RESP_OKAY : `TMZ_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ===== tmz_timer_sva.sv
`timescale 1ns/1ps
module tmz_timer_sva (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic watchdog_tick_i,
    input wire logic watchdog_tick_o,
    input wire logic porta_pullup_disable_o,
    input wire logic ext_irq_edge_select_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence opt_write;
        wr_taken ##0 (s_axi_awaddr[7:0] == 8'h00 && s_axi_wstrb[0]);
    endsequence
    chk_write_answer: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_option_reset: assert property ($rose(rst_b_i) |-> porta_pullup_disable_o && ext_irq_edge_select_o)
        else $error("option bits not set after reset");
    chk_option_outs: assert property (opt_write |=> porta_pullup_disable_o == $past(s_axi_wdata[7])
        && ext_irq_edge_select_o == $past(s_axi_wdata[6]))
        else $error("option outputs do not follow write");
    chk_wdt_tick_cause: assert property (watchdog_tick_o |-> watchdog_tick_i)
        else $error("watchdog tick without base tick");
endmodule
bind tmz_timer tmz_timer_sva u_chk (.*);

// ===== tmz_pulse_src.sv
`timescale 1ns/1ps
module tmz_pulse_src (
    input wire logic clk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    task automatic park();
        @(posedge clk_i);
        pin_o <= 1'b0;
    endtask
    // Ends high: n rising edges, n-1 falling edges
    task automatic burst(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(posedge clk_i);
            pin_o <= 1'b1;
            if (i < n - 1) begin
                repeat (half) @(posedge clk_i);
                pin_o <= 1'b0;
            end
        end
    endtask
endmodule

// ===== tmz_timer_test.sv
`timescale 1ns/1ps
module tmz_timer_test;
    logic clk_i = 1'b0, rst_b_i = 1'b0, sleep_i = 1'b0, ext_count_pin_i, watchdog_clear_instr_i = 1'b0;
    logic watchdog_tick_i = 1'b0, watchdog_tick_o, porta_pullup_disable_o, ext_irq_edge_select_o;
    logic overflow_irq_o, irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] lfsr = 8'h4c, rd, a;
    int n_fail = 0, check_count = 0, cyc = 0, nt = 0;
    always #12.5 clk_i = ~clk_i;
    tmz_timer dut (.clk_i, .rst_b_i, .sleep_i, .ext_count_pin_i, .watchdog_clear_instr_i,
        .watchdog_tick_i, .watchdog_tick_o, .porta_pullup_disable_o, .ext_irq_edge_select_o,
        .overflow_irq_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    tmz_pulse_src u_src (.clk_i, .pin_o(ext_count_pin_i));
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (watchdog_tick_o === 1'b1) nt <= nt + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic ck(input string nm, input logic [7:0] e, s, input int tol);
        check_count++;
        if (!(s === e || (tol > 0 && (s === e + 8'h1 || s === e - 8'h1)))) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] off, d);
        logic aw, w, b;
        @(posedge clk_i);
        s_axi_awaddr <= {24'h0, off};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            #1;
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid & s_axi_bready;
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rdr(input logic [7:0] off, output logic [7:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge clk_i);
        s_axi_araddr <= {24'h0, off};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        while (!v) begin
            #1;
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            @(posedge clk_i);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic tick(input logic clr);
        @(posedge clk_i);
        watchdog_clear_instr_i <= clr;
        watchdog_tick_i <= !clr;
        @(posedge clk_i);
        watchdog_clear_instr_i <= 1'b0;
        watchdog_tick_i <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        ck("pullup", 8'h1, 8'(porta_pullup_disable_o), 0);
        rdr(8'h0, rd, rs);
        ck("option", 8'hff, rd, 0);
        rdr(8'h8, rd, rs);
        ck("intctl", 8'h00, rd, 0);
        rdr(8'h14, rd, rs);
        ck("unmapped", 8'h2, 8'(rs), 0);
        wr(8'h0, 8'h48);
        ck("pullup", 8'h0, 8'(porta_pullup_disable_o), 0);
        ck("irq edge", 8'h1, 8'(ext_irq_edge_select_o), 0);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            wr(8'h4, lfsr);
            repeat (16) @(posedge clk_i);
            rdr(8'h4, rd, rs);
            ck("count direct", lfsr + 8'h3, rd, 1);
        end
        tick(1'b1);
        for (int r = 0; r < 8; r++) begin
            wr(8'h0, 8'(r));
            wr(8'h4, 8'h00);
            repeat (4 + (28 << r)) @(posedge clk_i);
            rdr(8'h4, rd, rs);
            ck("prescaled", 8'h3, rd, 1);
        end
        tick(1'b1);
        wr(8'h4, 8'h00);
        wr(8'h0, 8'h08);
        tick(1'b1);
        wr(8'h10, 8'h00);
        wr(8'h8, 8'h00);
        wr(8'h4, 8'hfd);
        repeat (40) @(posedge clk_i);
        rdr(8'h8, rd, rs);
        ck("flag", 8'h04, rd, 0);
        ck("ovf irq", 8'h0, 8'(overflow_irq_o), 0);
        ck("irq masked", 8'h0, 8'(irq_o), 0);
        wr(8'h10, 8'h01);
        ck("irq", 8'h1, 8'(irq_o), 0);
        rdr(8'hc, rd, rs);
        ck("status", 8'h01, rd, 0);
        ck("irq cleared", 8'h0, 8'(irq_o), 0);
        wr(8'h8, 8'h24);
        ck("ovf irq", 8'h1, 8'(overflow_irq_o), 0);
        wr(8'h8, 8'h20);
        ck("ovf irq", 8'h0, 8'(overflow_irq_o), 0);
        for (int e = 0; e < 2; e++) begin
            u_src.park();
            wr(8'h0, 8'h28 | 8'(e << 4));
            wr(8'h4, 8'h00);
            repeat (12) @(posedge clk_i);
            u_src.burst(5, 3 + 6 * e);
            repeat (12) @(posedge clk_i);
            rdr(8'h4, rd, rs);
            ck("ext edges", 8'(5 - e), rd, 0);
        end
        wr(8'h0, 8'h08);
        wr(8'h4, 8'h40);
        sleep_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rdr(8'h4, a, rs);
        repeat (40) @(posedge clk_i);
        rdr(8'h4, rd, rs);
        ck("frozen", a, rd, 0);
        sleep_i <= 1'b0;
        wr(8'h0, 8'h09);
        a = 8'(nt);
        tick(1'b1);
        tick(1'b0);
        tick(1'b1);
        tick(1'b0);
        ck("wdt cleared", a, 8'(nt), 0);
        tick(1'b0);
        #1;
        ck("wdt div", a + 8'h1, 8'(nt), 0);
        complete_run();
    end
endmodule
